/* File: common/recb_pkg.sv */
package recb_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CHAN_N = 16;

  // register offsets
  localparam logic [7:0] OFS_ACT_CONV = 8'hb1;
  localparam logic [7:0] OFS_ACT_LINREG_LOW = 8'hb2;
  localparam logic [7:0] OFS_ACT_LINREG_HIGH = 8'hb3;
  localparam logic [7:0] OFS_ACT_SWITCH_MISC = 8'hb4;
  localparam logic [7:0] OFS_SLP_CONV_SW = 8'hb5;
  localparam logic [7:0] OFS_SLP_LINREG = 8'hb6;
  localparam logic [7:0] OFS_DRN_CONV_SW = 8'hb7;
  localparam logic [7:0] OFS_DRN_LINREG = 8'hb8;
  localparam logic [7:0] OFS_POWER_CONFIG = 8'hb9;

  // reset values of plain registers
  localparam logic [7:0] DRAIN_RESET = 8'hff;
  localparam logic [3:0] CONFIG_RESET = 4'h0;
  localparam logic [3:0] GUARD_RESET = 4'h0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam logic [3:0] CONFIG_LOW_ZERO = 4'h0;

  // field layout of active registers: enables low nibble, guards high nibble
  localparam int unsigned ENABLE_LSB = 0;
  localparam int unsigned GUARD_LSB = 4;
  localparam int unsigned FIELD_W = 4;
  localparam int unsigned HIGH_LSB = 4;
  localparam int unsigned LOW_LSB = 0;

  // channel vector: four-channel groups, linear regulators 1..8 as one byte
  localparam int unsigned GRP_CONV_LSB = 0;
  localparam int unsigned GRP_LINREG_LSB = 4;
  localparam int unsigned GRP_LINREG_HIGH_LSB = 8;
  localparam int unsigned GRP_MISC_LSB = 12;
  localparam int unsigned LINREG_W = 8;

  // field positions in the configuration register
  localparam int unsigned CFG_LINREG_LP_BIT = 7;
  localparam int unsigned CFG_CONV3_FB_BIT = 6;
  localparam int unsigned CFG_BYPASS_BIT = 5;
  localparam int unsigned CFG_3V_LP_BIT = 4;
  localparam int unsigned CFG_LSB = 4;

  // default-load sequencer
  typedef enum logic [1:0] {
    RECB_LOAD = 2'b01,
    RECB_RUN = 2'b10
  } recb_state_e;
endpackage

/* File: core/recb_sync3.sv */
`timescale 1ns/100ps
module recb_sync3 (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level
);
  import recb_pkg::*;

  logic stage1;
  logic stage2;
  logic stage3;

  // level moves only when the second and third stages agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level <= 1'b0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        level <= stage3;
      end
    end
  end
endmodule

/* File: core/recb_guarded_reg.sv */
`timescale 1ns/100ps
module recb_guarded_reg (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [recb_pkg::FIELD_W-1:0] load_value,
  input wire logic wr,
  input wire logic [recb_pkg::DATA_W-1:0] wdata,
  output logic [recb_pkg::DATA_W-1:0] q
);
  import recb_pkg::*;

  logic [FIELD_W-1:0] enable;
  logic [FIELD_W-1:0] guard;
  logic [FIELD_W-1:0] next_enable;
  logic [FIELD_W-1:0] wr_enable;
  logic [FIELD_W-1:0] wr_guard;

  assign wr_enable = wdata[ENABLE_LSB +: FIELD_W];
  assign wr_guard = wdata[GUARD_LSB +: FIELD_W];

  genvar i;
  generate
    for (i = 0; i < FIELD_W; i++) begin : g_bit
      // each enable moves only when its own guard is written as one
      assign next_enable[i] = (wr && wr_guard[i]) ? wr_enable[i] : enable[i];
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      enable <= '0;
      guard <= GUARD_RESET;
    end else if (load) begin
      enable <= load_value;
      guard <= GUARD_RESET;
    end else begin
      enable <= next_enable;
      if (wr) begin
        guard <= wr_guard;
      end
    end
  end

  assign q = {guard, enable};
endmodule

/* File: core/recb_top.sv */
`timescale 1ns/100ps
module recb_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [recb_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [recb_pkg::DATA_W-1:0] reg_wdata,
  output logic [recb_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [recb_pkg::CHAN_N-1:0] otp_active_default,
  input wire logic [recb_pkg::CHAN_N-1:0] otp_sleep_default,
  input wire logic sleep_pin,
  output logic [recb_pkg::CHAN_N-1:0] chan_on,
  output logic [recb_pkg::CHAN_N-1:0] chan_drain,
  output logic linreg_low_power_on,
  output logic converter3_feedback_source,
  output logic three_volt_regulator_bypass,
  output logic three_volt_regulator_low_power
);
  import recb_pkg::*;

  recb_state_e state;
  recb_state_e next_state;
  logic load;
  logic run;
  logic sleep_mode;

  logic [DATA_W-1:0] act_conv;
  logic [DATA_W-1:0] act_linreg_low;
  logic [DATA_W-1:0] act_linreg_high;
  logic [DATA_W-1:0] act_switch_misc;
  logic [DATA_W-1:0] sleep_enable_converters_switches;
  logic [DATA_W-1:0] sleep_enable_linregs;
  logic [DATA_W-1:0] discharge_enable_converters_switches;
  logic [DATA_W-1:0] discharge_enable_linregs;
  logic [FIELD_W-1:0] power_option_config;

  logic wr_ok;
  logic sel_act_conv;
  logic sel_act_low;
  logic sel_act_high;
  logic sel_act_misc;
  logic sel_slp_cs;
  logic sel_slp_lr;
  logic sel_drn_cs;
  logic sel_drn_lr;
  logic sel_cfg;
  logic [DATA_W-1:0] next_rdata;
  logic [CHAN_N-1:0] active_vec;
  logic [CHAN_N-1:0] sleep_vec;
  logic [CHAN_N-1:0] drain_vec;
  logic [CHAN_N-1:0] next_chan_on;
  logic [DATA_W-1:0] sleep_default_cs;
  logic [DATA_W-1:0] sleep_default_lr;
  logic wr_act_conv;
  logic wr_act_low;
  logic wr_act_high;
  logic wr_act_misc;
  logic wr_slp_cs;
  logic wr_slp_lr;
  logic wr_drn_cs;
  logic wr_drn_lr;
  logic wr_cfg;
  logic [CHAN_N-1:0] next_chan_drain;
  logic cfg_linreg_lp;
  logic cfg_conv3_fb;
  logic cfg_bypass;
  logic cfg_3v_lp;

  // defaults cannot enter under async reset; loaded at first edge after release
  always_comb begin
    case (state)
      RECB_LOAD: next_state = RECB_RUN;
      RECB_RUN: next_state = RECB_RUN;
      default: next_state = RECB_LOAD;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= RECB_LOAD;
    end else begin
      state <= next_state;
    end
  end

  assign load = (state == RECB_LOAD);
  assign run = (state == RECB_RUN);
  assign wr_ok = reg_wr && run;

  recb_sync3 u_sleep_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin(sleep_pin),
    .level(sleep_mode)
  );

  // address decode
  assign sel_act_conv = (reg_addr == OFS_ACT_CONV);
  assign sel_act_low = (reg_addr == OFS_ACT_LINREG_LOW);
  assign sel_act_high = (reg_addr == OFS_ACT_LINREG_HIGH);
  assign sel_act_misc = (reg_addr == OFS_ACT_SWITCH_MISC);
  assign sel_slp_cs = (reg_addr == OFS_SLP_CONV_SW);
  assign sel_slp_lr = (reg_addr == OFS_SLP_LINREG);
  assign sel_drn_cs = (reg_addr == OFS_DRN_CONV_SW);
  assign sel_drn_lr = (reg_addr == OFS_DRN_LINREG);
  assign sel_cfg = (reg_addr == OFS_POWER_CONFIG);

  // write strobes per register, held off while defaults load
  assign wr_act_conv = wr_ok && sel_act_conv;
  assign wr_act_low = wr_ok && sel_act_low;
  assign wr_act_high = wr_ok && sel_act_high;
  assign wr_act_misc = wr_ok && sel_act_misc;
  assign wr_slp_cs = wr_ok && sel_slp_cs;
  assign wr_slp_lr = wr_ok && sel_slp_lr;
  assign wr_drn_cs = wr_ok && sel_drn_cs;
  assign wr_drn_lr = wr_ok && sel_drn_lr;
  assign wr_cfg = wr_ok && sel_cfg;

  // guarded active-enable registers
  recb_guarded_reg u_act_conv (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(load),
    .load_value(otp_active_default[GRP_CONV_LSB +: FIELD_W]),
    .wr(wr_act_conv),
    .wdata(reg_wdata),
    .q(act_conv)
  );

  recb_guarded_reg u_act_low (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(load),
    .load_value(otp_active_default[GRP_LINREG_LSB +: FIELD_W]),
    .wr(wr_act_low),
    .wdata(reg_wdata),
    .q(act_linreg_low)
  );

  recb_guarded_reg u_act_high (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(load),
    .load_value(otp_active_default[GRP_LINREG_HIGH_LSB +: FIELD_W]),
    .wr(wr_act_high),
    .wdata(reg_wdata),
    .q(act_linreg_high)
  );

  recb_guarded_reg u_act_misc (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(load),
    .load_value(otp_active_default[GRP_MISC_LSB +: FIELD_W]),
    .wr(wr_act_misc),
    .wdata(reg_wdata),
    .q(act_switch_misc)
  );

  // sleep defaults rearranged into register layout
  assign sleep_default_cs = {otp_sleep_default[GRP_MISC_LSB +: FIELD_W],
                             otp_sleep_default[GRP_CONV_LSB +: FIELD_W]};
  assign sleep_default_lr = otp_sleep_default[GRP_LINREG_LSB +: LINREG_W];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_enable_converters_switches <= '0;
    end else if (load) begin
      sleep_enable_converters_switches <= sleep_default_cs;
    end else if (wr_slp_cs) begin
      sleep_enable_converters_switches <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_enable_linregs <= '0;
    end else if (load) begin
      sleep_enable_linregs <= sleep_default_lr;
    end else if (wr_slp_lr) begin
      sleep_enable_linregs <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      discharge_enable_converters_switches <= DRAIN_RESET;
    end else if (wr_drn_cs) begin
      discharge_enable_converters_switches <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      discharge_enable_linregs <= DRAIN_RESET;
    end else if (wr_drn_lr) begin
      discharge_enable_linregs <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      power_option_config <= CONFIG_RESET;
    end else if (wr_cfg) begin
      power_option_config <= reg_wdata[CFG_LSB +: FIELD_W];
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = READ_UNMAPPED;
    case (1'b1)
      sel_act_conv: next_rdata = act_conv;
      sel_act_low: next_rdata = act_linreg_low;
      sel_act_high: next_rdata = act_linreg_high;
      sel_act_misc: next_rdata = act_switch_misc;
      sel_slp_cs: next_rdata = sleep_enable_converters_switches;
      sel_slp_lr: next_rdata = sleep_enable_linregs;
      sel_drn_cs: next_rdata = discharge_enable_converters_switches;
      sel_drn_lr: next_rdata = discharge_enable_linregs;
      sel_cfg: next_rdata = {power_option_config, CONFIG_LOW_ZERO};
      default: next_rdata = READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= READ_UNMAPPED;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // channel order: conv1-4, linreg1-8, linreg9, conv5, switch1, switch2
  assign active_vec = {act_switch_misc[ENABLE_LSB +: FIELD_W],
                       act_linreg_high[ENABLE_LSB +: FIELD_W],
                       act_linreg_low[ENABLE_LSB +: FIELD_W],
                       act_conv[ENABLE_LSB +: FIELD_W]};
  assign sleep_vec = {sleep_enable_converters_switches[HIGH_LSB +: FIELD_W],
                      sleep_enable_linregs,
                      sleep_enable_converters_switches[LOW_LSB +: FIELD_W]};
  assign drain_vec = {discharge_enable_converters_switches[HIGH_LSB +: FIELD_W],
                      discharge_enable_linregs,
                      discharge_enable_converters_switches[LOW_LSB +: FIELD_W]};

  // per-channel source pick; drain only on channels that end up off
  genvar ch;
  generate
    for (ch = 0; ch < CHAN_N; ch++) begin : g_chan
      assign next_chan_on[ch] = sleep_mode ? sleep_vec[ch] : active_vec[ch];
      assign next_chan_drain[ch] = ~next_chan_on[ch] & drain_vec[ch];
    end
  endgenerate

  assign cfg_linreg_lp = power_option_config[CFG_LINREG_LP_BIT - CFG_LSB];
  assign cfg_conv3_fb = power_option_config[CFG_CONV3_FB_BIT - CFG_LSB];
  assign cfg_bypass = power_option_config[CFG_BYPASS_BIT - CFG_LSB];
  assign cfg_3v_lp = power_option_config[CFG_3V_LP_BIT - CFG_LSB];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chan_on <= '0;
      chan_drain <= '0;
    end else begin
      chan_on <= next_chan_on;
      chan_drain <= next_chan_drain;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      linreg_low_power_on <= 1'b0;
      converter3_feedback_source <= 1'b0;
      three_volt_regulator_bypass <= 1'b0;
      three_volt_regulator_low_power <= 1'b0;
    end else begin
      linreg_low_power_on <= cfg_linreg_lp;
      converter3_feedback_source <= cfg_conv3_fb;
      three_volt_regulator_bypass <= cfg_bypass;
      three_volt_regulator_low_power <= cfg_3v_lp;
    end
  end
endmodule

/* File: verif/recb_top_properties.sv */
`timescale 1ns/100ps
module recb_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [recb_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [recb_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [recb_pkg::DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [recb_pkg::CHAN_N-1:0] chan_on,
  input wire logic [recb_pkg::CHAN_N-1:0] chan_drain,
  input wire logic linreg_low_power_on,
  input wire logic converter3_feedback_source,
  input wire logic three_volt_regulator_bypass,
  input wire logic three_volt_regulator_low_power
);
  import recb_pkg::*;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire unm = reg_addr < OFS_ACT_CONV || reg_addr > OFS_POWER_CONFIG;
  wire cfg_wr = reg_wr && reg_addr == OFS_POWER_CONFIG;
  chk_drain_off_only: assert property ((chan_drain & chan_on) == '0)
    else $error("drain engaged on live channel");
  chk_reset_quiet: assert property ($rose(rst_n) |-> chan_on == '0)
    else $error("channel on straight after reset");
  chk_rvalid_follow: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read valid without read");
  chk_unmapped_zero: assert property (reg_rd && unm |=> reg_rdata == READ_UNMAPPED)
    else $error("unmapped read not zero");
  chk_lp_follow: assert property (cfg_wr && $past(rst_n) |=>
    ##1 linreg_low_power_on == $past(reg_wdata[7], 2))
    else $error("low power bit mismatch");
  chk_fb_follow: assert property (cfg_wr && $past(rst_n) |=>
    ##1 converter3_feedback_source == $past(reg_wdata[6], 2))
    else $error("feedback select mismatch");
  chk_bypass_follow: assert property (cfg_wr && $past(rst_n) |=>
    ##1 three_volt_regulator_bypass == $past(reg_wdata[5], 2))
    else $error("bypass bit mismatch");
  chk_lp3_follow: assert property (cfg_wr && $past(rst_n) |=>
    ##1 three_volt_regulator_low_power == $past(reg_wdata[4], 2))
    else $error("3V low power bit mismatch");
endmodule
bind recb_top recb_chk u_chk (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .chan_on(chan_on), .chan_drain(chan_drain), .linreg_low_power_on(linreg_low_power_on),
  .converter3_feedback_source(converter3_feedback_source),
  .three_volt_regulator_bypass(three_volt_regulator_bypass),
  .three_volt_regulator_low_power(three_volt_regulator_low_power));

/* File: verif/recb_host.sv */
`timescale 1ns/100ps
module recb_host (
  input wire logic mclk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // guards cleared once enables are set
  task automatic en_wr(input logic [7:0] a, input logic [7:0] d);
    wr(a, d);
    wr(a, {4'h0, d[3:0]});
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    // answer stands exactly one cycle after the strobe; a late one reads unknown
    d = reg_rvalid ? reg_rdata : 8'hxx;
  endtask
endmodule

/* File: verif/regulator_enable_control_bank_tb.sv */
`timescale 1ns/100ps
module regulator_enable_control_bank_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic sleep_pin = 1'b0;
  logic reg_wr, reg_rd, reg_rvalid, lp, fb, byp, lp3;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, a8, w;
  logic [15:0] otp_a = 16'h0000;
  logic [15:0] otp_s = 16'h0000;
  logic [15:0] chan_on, chan_drain, rnd;
  logic [7:0] m [16];
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  always #4 mclk = ~mclk;
  recb_top dut (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .otp_active_default(otp_a), .otp_sleep_default(otp_s),
    .sleep_pin(sleep_pin), .chan_on(chan_on), .chan_drain(chan_drain),
    .linreg_low_power_on(lp), .converter3_feedback_source(fb),
    .three_volt_regulator_bypass(byp), .three_volt_regulator_low_power(lp3));
  recb_host host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] upd(input logic [7:0] a, o, x);
    if (a >= 8'hb1 && a <= 8'hb4) return {x[7:4], (x[7:4] & x[3:0]) | (~x[7:4] & o[3:0])};
    if (a >= 8'hb5 && a <= 8'hb8) return x;
    if (a == 8'hb9) return {x[7:4], 4'h0};
    return o;
  endfunction
  task automatic chk(input logic [15:0] g, e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic outs();
    logic [15:0] on;
    on = sleep_pin ? {m[5][7:4], m[6], m[5][3:0]}
                   : {m[4][3:0], m[3][3:0], m[2][3:0], m[1][3:0]};
    chk(chan_on, on);
    chk(chan_drain, ~on & {m[7][7:4], m[8], m[7][3:0]});
    chk({lp, fb, byp, lp3}, m[9][7:4]);
  endtask
  task automatic rst();
    @(negedge mclk);
    rst_n = 1'b0;
    otp_a = rnd;
    otp_s = nx(rnd);
    rnd = nx(otp_s);
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    m = '{default: 8'h00};
    m[1] = {4'h0, otp_a[3:0]};
    m[2] = {4'h0, otp_a[7:4]};
    m[3] = {4'h0, otp_a[11:8]};
    m[4] = {4'h0, otp_a[15:12]};
    m[5] = {otp_s[15:12], otp_s[3:0]};
    m[6] = otp_s[11:4];
    m[7] = 8'hff;
    m[8] = 8'hff;
    repeat (3) @(negedge mclk);
  endtask
  task automatic end_sim();
    if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    rnd = 16'h0051;
    for (int r = 0; r < 2; r++) begin
      rst();
      for (int a = 'hb0; a <= 'hba; a++) begin
        host.rd(8'(a), d);
        chk(d, m[a[3:0]]);
      end
      outs();
      for (int a = 'hb1; a <= 'hb4; a++) begin
        host.wr(8'(a), {4'h0, ~m[a[3:0]][3:0]});
        host.rd(8'(a), d);
        chk(d, m[a[3:0]]);
      end
      for (int i = 0; i < 50; i++) begin
        rnd = nx(rnd);
        a8 = 8'hb0 + 8'(rnd[7:0] % 11);
        w = 8'(nx(rnd) >> 8);
        if (rnd[3]) begin
          host.en_wr(a8, w);
          m[a8[3:0]] = upd(a8, upd(a8, m[a8[3:0]], w), {4'h0, w[3:0]});
        end else begin
          host.wr(a8, w);
          m[a8[3:0]] = upd(a8, m[a8[3:0]], w);
        end
        host.rd(a8, d);
        chk(d, m[a8[3:0]]);
        sleep_pin = rnd[9];
        repeat (8) @(negedge mclk);
        outs();
      end
    end
    end_sim();
  end
endmodule
